//--- rtl/scm_control_regs.sv
// Channel 8 reset routing, control, auto-mask and bank select registers
// Assumes register strobes come from same-clock serial bus logic and that
// fault comparators and the activation pin are asynchronous
`timescale 1ns/1ps
`include "scm_regs.svh"

// Functional notes
// R1 - Bit 4 routes monitor 8 overvoltage to reset
// R2 - Bit 3 routes monitor 8 undervoltage to reset
// R3 - Routing register at 95h, reserved bits read zero
// R4 - Writing 1 to control bit 7 starts self-test
// R5 - Control bit 5 holds reset output low
// R6 - Control bits 2-0 select reset release delay
// R7 - A1h masks monitors 8..2 during power-up
// R8 - A2h masks monitors 8..1 during power-down
// R9 - A3h masks monitors during sleep exit
// R10 - A4h masks monitors during sleep entry
// R11 - F0h bit 0 selects bank, rest zero
// R12 - Fault flags stay set until write-one clear
// R13 - Activation pin high active, low shutdown
// R14 - Reset released only after selected delay
// R15 - Masks block reporting only during their transition
module scm_control_regs
	import scm_pkg::*;
#(
	parameter int DLY_CYC_0 = `SCM_DLY_US_0 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_1 = `SCM_DLY_US_1 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_2 = `SCM_DLY_US_2 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_3 = `SCM_DLY_US_3 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_4 = `SCM_DLY_US_4 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_5 = `SCM_DLY_US_5 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_6 = `SCM_DLY_US_6 * `SCM_CLK_MHZ,
	parameter int DLY_CYC_7 = `SCM_DLY_US_7 * `SCM_CLK_MHZ
)
(
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	// Register access from the serial bus logic
	input  wire logic       reg_wr_en_in,
	input  wire logic       reg_rd_en_in,
	input  wire scm_byte_t  reg_addr_in,
	input  wire scm_byte_t  reg_wdata_in,
	output scm_byte_t       reg_rdata_out,
	output logic            reg_rd_valid_out,
	// Comparator outputs, asynchronous
	input  wire logic [7:0] fast_overvoltage_fault_in,
	input  wire logic [7:0] fast_undervoltage_fault_in,
	// Activation pin, asynchronous
	input  wire logic       activation_pin_in,
	// Transition phases from the sequencer
	input  wire logic       powerup_transition_in,
	input  wire logic       powerdown_transition_in,
	input  wire logic       sleep_exit_transition_in,
	input  wire logic       sleep_entry_transition_in,
	// Write-one clear strobes from the status registers
	input  wire logic [7:0] ov_flag_clear_in,
	input  wire logic [7:0] uv_flag_clear_in,
	// Fault flags
	output logic [7:0]      ov_flag_out,
	output logic [7:0]      uv_flag_out,
	// Pins and strobes
	output logic            reset_output_low_out,
	output logic            fault_interrupt_output_low_out,
	output logic            start_selftest_out,
	output logic            bank_select_out
);

	logic       route_ov_reg;
	logic       route_uv_reg;
	logic       bist_reg;
	logic       manual_reset_reg;
	logic [2:0] dly_sel_reg;
	scm_byte_t  pu_mask_reg;
	scm_byte_t  pd_mask_reg;
	scm_byte_t  sx_mask_reg;
	scm_byte_t  sn_mask_reg;
	logic       bank_reg;
	logic [7:0] ov_meta_reg;
	logic [7:0] ov_sync_reg;
	logic [7:0] uv_meta_reg;
	logic [7:0] uv_sync_reg;
	logic       act_meta_reg;
	logic       act_sync_reg;
	logic [7:0] mask_hit;
	logic       reset_hold;
	scm_count_t delay_cycles;
	scm_byte_t  rd_next;
	logic       wr_route;
	logic       wr_ctrl;
	logic       wr_pu;
	logic       wr_pd;
	logic       wr_sx;
	logic       wr_sn;
	logic       wr_bank;

	// Bank 0 holds every register here except the bank select itself
	function automatic logic bank0_hit(input scm_byte_t addr, input scm_byte_t offs,
		input logic bank);
		bank0_hit = (addr == offs) && (bank == `SCM_BANK0);
	endfunction : bank0_hit

	function automatic scm_count_t delay_lookup(input logic [2:0] sel);
		case (sel)
			3'h0:    delay_lookup = scm_count_t'(DLY_CYC_0);
			3'h1:    delay_lookup = scm_count_t'(DLY_CYC_1);
			3'h2:    delay_lookup = scm_count_t'(DLY_CYC_2);
			3'h3:    delay_lookup = scm_count_t'(DLY_CYC_3);
			3'h4:    delay_lookup = scm_count_t'(DLY_CYC_4);
			3'h5:    delay_lookup = scm_count_t'(DLY_CYC_5);
			3'h6:    delay_lookup = scm_count_t'(DLY_CYC_6);
			default: delay_lookup = scm_count_t'(DLY_CYC_7);
		endcase
	endfunction : delay_lookup

	assign wr_route = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_ROUTE, bank_reg);
	assign wr_ctrl  = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_CTRL, bank_reg);
	assign wr_pu    = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_PU_MASK, bank_reg);
	assign wr_pd    = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_PD_MASK, bank_reg);
	assign wr_sx    = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_SX_MASK, bank_reg);
	assign wr_sn    = reg_wr_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_SN_MASK, bank_reg);
	assign wr_bank  = reg_wr_en_in && (reg_addr_in == `SCM_ADDR_BANK);

	// Synchronisers for comparators and the activation pin
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ov_meta_reg  <= `SCM_RST_BYTE;
			ov_sync_reg  <= `SCM_RST_BYTE;
			uv_meta_reg  <= `SCM_RST_BYTE;
			uv_sync_reg  <= `SCM_RST_BYTE;
			act_meta_reg <= `SCM_RST_BIT;
			act_sync_reg <= `SCM_RST_BIT;
		end else begin
			ov_meta_reg  <= fast_overvoltage_fault_in;
			ov_sync_reg  <= ov_meta_reg;
			uv_meta_reg  <= fast_undervoltage_fault_in;
			uv_sync_reg  <= uv_meta_reg;
			act_meta_reg <= activation_pin_in;
			act_sync_reg <= act_meta_reg;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			route_ov_reg <= `SCM_RST_BIT;
			route_uv_reg <= `SCM_RST_BIT;
		end else if (wr_route) begin
			route_ov_reg <= reg_wdata_in[`SCM_ROUTE_OV_BIT]; // R1
			route_uv_reg <= reg_wdata_in[`SCM_ROUTE_UV_BIT]; // R2
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bist_reg         <= `SCM_RST_BIT;
			manual_reset_reg <= `SCM_RST_BIT;
			dly_sel_reg      <= `SCM_RESET_RELEASE_DELAY;
		end else if (wr_ctrl) begin
			bist_reg         <= reg_wdata_in[`SCM_CTRL_BIST_BIT];
			manual_reset_reg <= reg_wdata_in[`SCM_CTRL_MR_BIT]; // R5
			dly_sel_reg      <= reg_wdata_in[`SCM_CTRL_DLY_MSB:`SCM_CTRL_DLY_LSB]; // R6
		end
	end

	// Each write of a one restarts the self-test, even if the bit was already set
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			start_selftest_out <= 1'b0;
		end else begin
			start_selftest_out <= wr_ctrl && reg_wdata_in[`SCM_CTRL_BIST_BIT]; // R4
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pu_mask_reg <= `SCM_RST_BYTE;
			pd_mask_reg <= `SCM_RST_BYTE;
			sx_mask_reg <= `SCM_RST_BYTE;
			sn_mask_reg <= `SCM_RST_BYTE;
		end else begin
			if (wr_pu) begin
				pu_mask_reg <= reg_wdata_in & `SCM_PU_VALID; // R7
			end
			if (wr_pd) begin
				pd_mask_reg <= reg_wdata_in; // R8
			end
			if (wr_sx) begin
				sx_mask_reg <= reg_wdata_in; // R9
			end
			if (wr_sn) begin
				sn_mask_reg <= reg_wdata_in; // R10
			end
		end
	end

	// Bank select is reachable from either bank so software can always return
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bank_reg <= `SCM_BANK0;
		end else if (wr_bank) begin
			bank_reg <= reg_wdata_in[`SCM_BANK_BIT]; // R11
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bank_select_out <= `SCM_BANK0;
		end else begin
			bank_select_out <= bank_reg;
		end
	end

	always_comb begin
		rd_next = `SCM_RST_BYTE; // R3
		if (bank0_hit(reg_addr_in, `SCM_ADDR_ROUTE, bank_reg)) begin
			rd_next[`SCM_ROUTE_OV_BIT] = route_ov_reg;
			rd_next[`SCM_ROUTE_UV_BIT] = route_uv_reg;
		end else if (bank0_hit(reg_addr_in, `SCM_ADDR_CTRL, bank_reg)) begin
			rd_next[`SCM_CTRL_BIST_BIT] = bist_reg;
			rd_next[`SCM_CTRL_MR_BIT] = manual_reset_reg;
			rd_next[`SCM_CTRL_DLY_MSB:`SCM_CTRL_DLY_LSB] = dly_sel_reg;
		end else if (bank0_hit(reg_addr_in, `SCM_ADDR_PU_MASK, bank_reg)) begin
			rd_next = pu_mask_reg;
		end else if (bank0_hit(reg_addr_in, `SCM_ADDR_PD_MASK, bank_reg)) begin
			rd_next = pd_mask_reg;
		end else if (bank0_hit(reg_addr_in, `SCM_ADDR_SX_MASK, bank_reg)) begin
			rd_next = sx_mask_reg;
		end else if (bank0_hit(reg_addr_in, `SCM_ADDR_SN_MASK, bank_reg)) begin
			rd_next = sn_mask_reg;
		end else if (reg_addr_in == `SCM_ADDR_BANK) begin
			rd_next[`SCM_BANK_BIT] = bank_reg; // R11
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out    <= `SCM_RST_BYTE;
			reg_rd_valid_out <= 1'b0;
		end else begin
			reg_rd_valid_out <= reg_rd_en_in;
			if (reg_rd_en_in) begin
				reg_rdata_out <= rd_next;
			end
		end
	end

	// Per-monitor masking and sticky flags
	for (genvar n = 0; n < 8; n++) begin : g_mon
		// Mask only gates flag setting; comparators and reset routing keep running
		assign mask_hit[n] = (powerup_transition_in && pu_mask_reg[n]) ||
			(powerdown_transition_in && pd_mask_reg[n]) ||
			(sleep_exit_transition_in && sx_mask_reg[n]) ||
			(sleep_entry_transition_in && sn_mask_reg[n]); // R15

		// A fault in the clear cycle keeps the flag set
		always_ff @(posedge ref_clk_in or posedge reset_in) begin
			if (reset_in) begin
				ov_flag_out[n] <= 1'b0;
			end else if (ov_sync_reg[n] && act_sync_reg && !mask_hit[n]) begin // R13
				ov_flag_out[n] <= 1'b1; // R12
			end else if (ov_flag_clear_in[n]) begin
				ov_flag_out[n] <= 1'b0; // R12
			end
		end

		always_ff @(posedge ref_clk_in or posedge reset_in) begin
			if (reset_in) begin
				uv_flag_out[n] <= 1'b0;
			end else if (uv_sync_reg[n] && act_sync_reg && !mask_hit[n]) begin // R13
				uv_flag_out[n] <= 1'b1; // R12
			end else if (uv_flag_clear_in[n]) begin
				uv_flag_out[n] <= 1'b0; // R12
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fault_interrupt_output_low_out <= 1'b1;
		end else begin
			fault_interrupt_output_low_out <= !((|ov_flag_out) || (|uv_flag_out));
		end
	end

	// Routing uses the raw synchronised fault, independent of the auto-masks
	assign reset_hold = manual_reset_reg || // R5
		(route_ov_reg && ov_sync_reg[`SCM_CH8_IDX]) || // R1
		(route_uv_reg && uv_sync_reg[`SCM_CH8_IDX]); // R2
	assign delay_cycles = delay_lookup(dly_sel_reg); // R6

	scm_reset_timer u_reset_timer (
		.ref_clk_in      (ref_clk_in),
		.reset_in        (reset_in),
		.hold_in         (reset_hold),
		.delay_cycles_in (delay_cycles),
		.reset_low_out   (reset_output_low_out)
	);

	sequence s_bist_write;
		wr_ctrl && reg_wdata_in[`SCM_CTRL_BIST_BIT];
	endsequence

	sequence s_bist_pulse;
		start_selftest_out ##1 !start_selftest_out;
	endsequence

	property p_mask_holds(logic tr, logic mk);
		@(posedge ref_clk_in) disable iff (reset_in)
		(tr && mk && !ov_flag_out[`SCM_CH8_IDX] && !reg_wr_en_in) |=> !ov_flag_out[`SCM_CH8_IDX];
	endproperty

	manual_reset_a: assert property ( // R5
		@(posedge ref_clk_in) disable iff (reset_in)
		manual_reset_reg |=> !reset_output_low_out)
		else $error("manual reset bit did not hold reset low");

	route_ov_a: assert property ( // R1
		@(posedge ref_clk_in) disable iff (reset_in)
		(route_ov_reg && ov_sync_reg[`SCM_CH8_IDX]) |=> !reset_output_low_out)
		else $error("routed overvoltage did not assert reset");

	route_uv_a: assert property ( // R2
		@(posedge ref_clk_in) disable iff (reset_in)
		(route_uv_reg && uv_sync_reg[`SCM_CH8_IDX]) |=> !reset_output_low_out)
		else $error("routed undervoltage did not assert reset");

	reserved_zero_a: assert property ( // R3
		@(posedge ref_clk_in) disable iff (reset_in)
		(reg_rd_en_in && bank0_hit(reg_addr_in, `SCM_ADDR_ROUTE, bank_reg)) |=>
			(reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[2:0] == 3'h0 && reg_rd_valid_out))
		else $error("routing register reserved bits not zero");

	selftest_start_a: assert property ( // R4
		@(posedge ref_clk_in) disable iff (reset_in)
		(s_bist_write ##1 !(wr_ctrl && reg_wdata_in[`SCM_CTRL_BIST_BIT])) |-> s_bist_pulse)
		else $error("self-test start pulse missing or too long");

	delay_select_a: assert property ( // R6
		@(posedge ref_clk_in) disable iff (reset_in)
		(wr_ctrl && reg_wdata_in[2:0] == 3'h1) |=> (delay_cycles == scm_count_t'(DLY_CYC_1)))
		else $error("reset delay selection not applied");

	pu_mask_a: assert property (p_mask_holds(powerup_transition_in, pu_mask_reg[7])) // R7
		else $error("power-up mask let a flag set");
	pd_mask_a: assert property (p_mask_holds(powerdown_transition_in, pd_mask_reg[7])) // R8
		else $error("power-down mask let a flag set");
	sx_mask_a: assert property (p_mask_holds(sleep_exit_transition_in, sx_mask_reg[7])) // R9
		else $error("sleep exit mask let a flag set");
	sn_mask_a: assert property (p_mask_holds(sleep_entry_transition_in, sn_mask_reg[7])) // R10
		else $error("sleep entry mask let a flag set");

	bank_write_a: assert property ( // R11
		@(posedge ref_clk_in) disable iff (reset_in)
		wr_bank |=> (bank_reg == $past(reg_wdata_in[0])) ##1 (bank_select_out == bank_reg))
		else $error("bank select did not follow write");

	sticky_flag_a: assert property ( // R12
		@(posedge ref_clk_in) disable iff (reset_in)
		(uv_flag_out[`SCM_CH1_IDX] && !uv_flag_clear_in[`SCM_CH1_IDX]) |=> uv_flag_out[`SCM_CH1_IDX])
		else $error("fault flag cleared without a clear");

	set_wins_a: assert property ( // R12
		@(posedge ref_clk_in) disable iff (reset_in)
		(ov_sync_reg[`SCM_CH1_IDX] && act_sync_reg && !mask_hit[`SCM_CH1_IDX]) |=>
			(ov_flag_out[`SCM_CH1_IDX] ##1 !fault_interrupt_output_low_out))
		else $error("fault lost or interrupt not raised");

	shutdown_quiet_a: assert property ( // R13
		@(posedge ref_clk_in) disable iff (reset_in)
		(!act_sync_reg && !ov_flag_out[`SCM_CH1_IDX]) |=> !ov_flag_out[`SCM_CH1_IDX])
		else $error("flag set while in shutdown");

endmodule : scm_control_regs

//--- rtl/scm_pkg.sv
// Types shared by the control and mask register block
// Assumes the constants header is on the include path
`include "scm_regs.svh"

package scm_pkg;

	typedef logic [7:0]              scm_byte_t;
	typedef logic [`SCM_CNT_W-1:0]   scm_count_t;

	typedef enum logic [1:0] {
		SCM_HOLD     = 2'b00,
		SCM_COUNT    = 2'b01,
		SCM_RELEASED = 2'b10
	} scm_rst_state_e;

endpackage : scm_pkg

//--- rtl/scm_regs.svh
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by bare name from the package and the design modules
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

// Register offsets
`define SCM_ADDR_ROUTE      8'h95
`define SCM_ADDR_CTRL       8'h9f
`define SCM_ADDR_PU_MASK    8'ha1
`define SCM_ADDR_PD_MASK    8'ha2
`define SCM_ADDR_SX_MASK    8'ha3
`define SCM_ADDR_SN_MASK    8'ha4
`define SCM_ADDR_BANK       8'hf0

// Field positions
`define SCM_ROUTE_OV_BIT    4
`define SCM_ROUTE_UV_BIT    3
`define SCM_CTRL_BIST_BIT   7
`define SCM_CTRL_MR_BIT     5
`define SCM_CTRL_DLY_MSB    2
`define SCM_CTRL_DLY_LSB    0
`define SCM_BANK_BIT        0
`define SCM_CH8_IDX         7
`define SCM_CH1_IDX         0

// Writable bits of the power-up mask; bit 0 is reserved
`define SCM_PU_VALID        8'hfe

// Reset values
`define SCM_RST_BYTE        8'h00
`define SCM_RST_BIT         1'b0
`define SCM_RESET_RELEASE_DELAY         3'h0
`define SCM_BANK0           1'b0
`define SCM_CNT_ZERO        25'h0000000
`define SCM_CNT_ONE         25'h0000001

// Reset release delays in microseconds, clock rate in MHz
`define SCM_CLK_MHZ         125
`define SCM_DLY_US_0        200
`define SCM_DLY_US_1        1000
`define SCM_DLY_US_2        10000
`define SCM_DLY_US_3        16000
`define SCM_DLY_US_4        20000
`define SCM_DLY_US_5        70000
`define SCM_DLY_US_6        100000
`define SCM_DLY_US_7        200000
`define SCM_CNT_W           25

`endif

//--- rtl/scm_reset_timer.sv
// Reset output release timer
// Assumes hold_in and delay_cycles_in are synchronous to ref_clk_in
`timescale 1ns/1ps
`include "scm_regs.svh"

module scm_reset_timer
	import scm_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       reset_in,
	// Control
	input  wire logic       hold_in,
	input  wire scm_count_t delay_cycles_in,
	// Reset pin level, low asserts
	output logic            reset_low_out
);

	scm_rst_state_e state_reg;
	scm_count_t     cnt_reg;

	// Power-on also runs the full delay before release
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= SCM_HOLD;
		end else begin
			case (state_reg)
				SCM_HOLD: begin
					if (!hold_in) begin
						state_reg <= SCM_COUNT; // R14
					end
				end
				SCM_COUNT: begin
					if (hold_in) begin
						state_reg <= SCM_HOLD;
					end else if (cnt_reg == `SCM_CNT_ZERO) begin
						state_reg <= SCM_RELEASED; // R14
					end
				end
				SCM_RELEASED: begin
					if (hold_in) begin
						state_reg <= SCM_HOLD;
					end
				end
				default: begin
					state_reg <= SCM_HOLD;
				end
			endcase
		end
	end

	// Delay is sampled while held, so a new selection applies to the next release
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_reg <= `SCM_CNT_ZERO;
		end else if (hold_in || state_reg == SCM_HOLD) begin
			cnt_reg <= delay_cycles_in - `SCM_CNT_ONE; // R14
		end else if (cnt_reg != `SCM_CNT_ZERO) begin
			cnt_reg <= cnt_reg - `SCM_CNT_ONE;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reset_low_out <= 1'b0;
		end else begin
			reset_low_out <= !hold_in && (state_reg == SCM_RELEASED ||
				(state_reg == SCM_COUNT && cnt_reg == `SCM_CNT_ZERO)); // R14
		end
	end

	release_after_count_a: assert property ( // R14
		@(posedge ref_clk_in) disable iff (reset_in)
		$rose(reset_low_out) |-> ($past(state_reg) == SCM_COUNT && $past(cnt_reg) == 0))
		else $error("reset released before delay ran out");

	delay_load_a: assert property ( // R14
		@(posedge ref_clk_in) disable iff (reset_in)
		(state_reg == SCM_HOLD && !hold_in) |=>
			(state_reg == SCM_COUNT && cnt_reg == scm_count_t'($past(delay_cycles_in) - 1)))
		else $error("delay count not loaded on hold release");

	hold_asserts_a: assert property ( // R14
		@(posedge ref_clk_in) disable iff (reset_in)
		hold_in |=> (!reset_low_out && state_reg == SCM_HOLD))
		else $error("reset not asserted while held");

endmodule : scm_reset_timer

//--- verification/scm_host_model.sv
// Host model: register strobes, activation pin and write-one clears
// Assumes callers invoke its tasks from the bench, one at a time
`timescale 1ns/1ps

module scm_host_model
	import scm_pkg::*;
(
	// Clock
	input  wire logic      ref_clk_in,
	// Register access
	output logic           reg_wr_en_out,
	output logic           reg_rd_en_out,
	output scm_byte_t      reg_addr_out,
	output scm_byte_t      reg_wdata_out,
	input  wire scm_byte_t reg_rdata_in,
	input  wire logic      reg_rd_valid_in,
	// Activation pin and flag clears
	output logic           activation_pin_out,
	output logic [7:0]     ov_flag_clear_out,
	output logic [7:0]     uv_flag_clear_out
);
	initial begin
		reg_wr_en_out = 1'b0;
		reg_rd_en_out = 1'b0;
		reg_addr_out = 8'h5a;
		reg_wdata_out = 8'ha5;
		activation_pin_out = 1'b1;
		ov_flag_clear_out = 8'h00;
		uv_flag_clear_out = 8'h00;
	end

	// Address and data flip once released, so stale values never look valid
	task automatic wr(input scm_byte_t a, input scm_byte_t d);
		@(negedge ref_clk_in);
		reg_wr_en_out = 1'b1;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(negedge ref_clk_in);
		reg_wr_en_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask : wr

	task automatic rd(input scm_byte_t a, output scm_byte_t d, output logic v);
		@(negedge ref_clk_in);
		reg_rd_en_out = 1'b1;
		reg_addr_out = a;
		@(negedge ref_clk_in);
		reg_rd_en_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
		v = reg_rd_valid_in;
	endtask : rd

	task automatic clr(input logic [7:0] ov, input logic [7:0] uv);
		@(negedge ref_clk_in);
		ov_flag_clear_out = ov;
		uv_flag_clear_out = uv;
		@(negedge ref_clk_in);
		ov_flag_clear_out = 8'h00;
		uv_flag_clear_out = 8'h00;
	endtask : clr

	task automatic set_act(input logic on);
		@(negedge ref_clk_in);
		activation_pin_out = on;
	endtask : set_act
endmodule : scm_host_model

//--- verification/tb.sv
// Self-checking bench for the control and mask register block
// Assumes delay codes 1-3 shortened to 6 + 4*code cycles; the others keep their real length
`timescale 1ns/1ps

module tb
	import scm_pkg::*;
();
	logic            clk;
	logic            reset;
	logic            wr_en;
	logic            rd_en;
	scm_byte_t       addr;
	scm_byte_t       wdata;
	scm_byte_t       rdata;
	logic            rd_valid;
	logic [7:0]      ov_f;
	logic [7:0]      uv_f;
	logic            act;
	logic [3:0]      trans;
	logic [7:0]      ov_clr;
	logic [7:0]      uv_clr;
	logic [7:0]      ov_flag;
	logic [7:0]      uv_flag;
	logic            rst_low;
	logic            int_low;
	logic            bist;
	logic            bank;
	int              err_count;
	int              n_checks;
	int              cycles;
	int              n;
	scm_byte_t       d;
	logic            v;
	scm_byte_t       addrs [7] = '{8'h95, 8'h9f, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hf0};
	scm_byte_t       rmask [7] = '{8'h18, 8'ha7, 8'hfe, 8'hff, 8'hff, 8'hff, 8'h01};
	scm_byte_t       rt_r [6] = '{8'h10, 8'h08, 8'h00, 8'h08, 8'h10, 8'h18};
	scm_byte_t       rt_o [6] = '{8'h80, 8'h00, 8'h80, 8'h80, 8'h00, 8'h7f};
	scm_byte_t       rt_u [6] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h80, 8'h7f};
	logic            rt_e [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam int   LIMIT = 40000;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	scm_host_model host (
		.ref_clk_in         (clk),
		.reg_wr_en_out      (wr_en),
		.reg_rd_en_out      (rd_en),
		.reg_addr_out       (addr),
		.reg_wdata_out      (wdata),
		.reg_rdata_in       (rdata),
		.reg_rd_valid_in    (rd_valid),
		.activation_pin_out (act),
		.ov_flag_clear_out  (ov_clr),
		.uv_flag_clear_out  (uv_clr)
	);

	// Code 0 keeps its real length so the shipped delay table is exercised once
	scm_control_regs #(
		.DLY_CYC_1 (10), .DLY_CYC_2 (14), .DLY_CYC_3 (18)
	) dut (
		.ref_clk_in                     (clk),
		.reset_in                       (reset),
		.reg_wr_en_in                   (wr_en),
		.reg_rd_en_in                   (rd_en),
		.reg_addr_in                    (addr),
		.reg_wdata_in                   (wdata),
		.reg_rdata_out                  (rdata),
		.reg_rd_valid_out               (rd_valid),
		.fast_overvoltage_fault_in      (ov_f),
		.fast_undervoltage_fault_in     (uv_f),
		.activation_pin_in              (act),
		.powerup_transition_in          (trans[0]),
		.powerdown_transition_in        (trans[1]),
		.sleep_exit_transition_in       (trans[2]),
		.sleep_entry_transition_in      (trans[3]),
		.ov_flag_clear_in               (ov_clr),
		.uv_flag_clear_in               (uv_clr),
		.ov_flag_out                    (ov_flag),
		.uv_flag_out                    (uv_flag),
		.reset_output_low_out           (rst_low),
		.fault_interrupt_output_low_out (int_low),
		.start_selftest_out             (bist),
		.bank_select_out                (bank)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic chk1(input logic seen, input logic exp);
		check({7'h00, seen}, {7'h00, exp});
	endtask : chk1

	task automatic rd_chk(input scm_byte_t a, input scm_byte_t exp);
		host.rd(a, d, v);
		chk1(v, 1'b1);
		check(d, exp);
	endtask : rd_chk

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			$display("MISMATCH at %0t: timeout", $time);
			end_of_test();
		end
	end

	initial begin
		err_count = 0;
		n_checks = 0;
		cycles = 0;
		ov_f = 8'h00;
		uv_f = 8'h00;
		trans = 4'h0;
		reset = 1'b1;
		repeat (5) @(negedge clk);
		chk1(rst_low, 1'b0);
		reset = 1'b0;
		foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
		// Bank register last, so bank 1 is left selected
		foreach (addrs[i]) begin
			host.wr(addrs[i], 8'hff);
			rd_chk(addrs[i], rmask[i]);
		end
		chk1(bank, 1'b1);
		rd_chk(8'h95, 8'h00);
		host.wr(8'ha2, 8'h00);
		host.wr(8'hf0, 8'h00);
		rd_chk(8'ha2, 8'hff);
		host.wr(8'h96, 8'hff);
		rd_chk(8'h96, 8'h00);
		for (int i = 0; i < 6; i++) host.wr(addrs[i], 8'h00);
		$display("Test register map done");

		host.wr(8'h9f, 8'h80);
		chk1(bist, 1'b1);
		@(negedge clk);
		chk1(bist, 1'b0);
		host.wr(8'h9f, 8'h00);
		chk1(bist, 1'b0);
		$display("Test self-test pulse done");

		for (int k = 7; k >= 0; k--) begin
			host.wr(8'h9f, 8'h20 | 8'(k));
			repeat (2) @(negedge clk);
			chk1(rst_low, 1'b0);
			host.wr(8'h9f, 8'(k));
			n = 0;
			while (rst_low !== 1'b1 && n < ((k > 3) ? 40 : 26000)) begin
				@(negedge clk);
				n++;
			end
			// Codes 4-7 last millions of cycles: only an early release is looked for
			// Code 0 is 200 us at 8 ns, plus the edge that raises the pin
			check(n, (k > 3) ? 40 : (k == 0) ? 25001 : 6 + 4 * k + 1);
		end
		// Short delay for the routing scenarios that follow
		host.wr(8'h9f, 8'h01);
		$display("Test release delays done");

		for (int i = 0; i < 6; i++) begin
			host.wr(8'h95, rt_r[i]);
			ov_f = rt_o[i];
			uv_f = rt_u[i];
			repeat (5) @(negedge clk);
			chk1(rst_low, rt_e[i]);
			ov_f = 8'h00;
			uv_f = 8'h00;
			repeat (20) @(negedge clk);
			chk1(rst_low, 1'b1);
		end
		host.wr(8'h95, 8'h00);
		host.clr(8'hff, 8'hff);
		$display("Test fault routing done");

		for (int t = 0; t < 4; t++) begin
			host.wr(8'ha1 + 8'(t), 8'hff);
			trans[t] = 1'b1;
			ov_f = 8'h80;
			uv_f = 8'h01;
			repeat (6) @(negedge clk);
			check(ov_flag, 8'h00);
			check(uv_flag, (t == 0) ? 8'h01 : 8'h00);
			trans[t] = 1'b0;
			repeat (5) @(negedge clk);
			check(ov_flag, 8'h80);
			ov_f = 8'h00;
			uv_f = 8'h00;
			repeat (5) @(negedge clk);
			check(ov_flag, 8'h80);
			chk1(int_low, 1'b0);
			host.clr(8'hff, 8'hff);
			repeat (2) @(negedge clk);
			check(ov_flag, 8'h00);
			chk1(int_low, 1'b1);
			host.wr(8'ha1 + 8'(t), 8'h00);
		end
		$display("Test auto-masks done");

		host.set_act(1'b0);
		ov_f = 8'hff;
		repeat (6) @(negedge clk);
		check(ov_flag, 8'h00);
		ov_f = 8'h00;
		repeat (4) @(negedge clk);
		host.set_act(1'b1);
		repeat (4) @(negedge clk);
		check(ov_flag, 8'h00);
		$display("Test shutdown done");
		end_of_test();
	end
endmodule : tb
